// file: hw/phm_consts.svh
// Function
// - The output latch keeps the data for the four general pins in bits 3 to 0, read and write, reset to zero.
// - In the six-pin build latch bits 5 and 4 hold output data too; in the four-pin build they are reserved and ignore writes.
// - Latch bits 7 and 6 are reserved, read as undefined and writes change nothing.
// - The pin-state register is read-only and a write to it changes no port state.
// - Pin-state bit 7 always returns the current level of the input-only pin.
// - Each general pin-state bit returns the latch bit when its direction bit is 1 and the pad level when it is 0.
// - Pin-state bit 6 is reserved and undefined, and so are bits 5 and 4 in the four-pin build.
// - With both tone enables at 0 the input-only pin is a general input that also feeds the timer clock; with either at 1 it carries the tone.
// - In the six-pin build pin 5 is the serial receive input when select and receiver enable are both set, otherwise a general pin.
// - A direction bit of 1 makes its pin an output and 0 an input while the pin is general I/O.
// - The direction register is write-only and reads return no stored direction bits.
`ifndef PHM_CONSTS_SVH
`define PHM_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define PHM_OFS_DIR      12'h000
`define PHM_OFS_LATCH    12'h004
`define PHM_OFS_STATE    12'h008
`define PHM_OFS_CTRL     12'h00C
// ----------------------------------------
// fields and resets
// ----------------------------------------
`define PHM_CTRL_COL     0
`define PHM_CTRL_ROW     1
`define PHM_CTRL_RXS     2
`define PHM_CTRL_RE      3
`define PHM_RST_BYTE     8'h00
`define PHM_RSVD_READ    8'h00
`define PHM_STATE_IN7    7
`define PHM_RESP_OKAY    2'h0
`define PHM_RESP_SLVERR  2'h2
`endif

// file: hw/phm_pkg.sv
package phm_pkg;
	typedef struct packed {
		logic tone_column_output_enable;
		logic tone_row_output_enable;
		logic serial_receive_pin_select;
		logic serial_receiver_enable;
	} phm_ctrl_t;
	typedef enum logic [1:0] {
		PHM_W_IDLE = 2'b01,
		PHM_W_RESP = 2'b10
	} phm_wst_t;
endpackage

// file: hw/phm_port.sv
`timescale 1ns/1ps
`include "phm_consts.svh"
module phm_port
	import phm_pkg::*;
#(
	parameter int SIX_PIN = 1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [5:0]  pad_in,
	output logic [5:0]       pad_out,
	output logic [5:0]       pad_oe,
	input  wire logic        input_only_pin,
	input  wire logic        tone_analog_output,
	output logic             tone_pin_select,
	output logic             reload_timer_clock_input,
	output logic             serial_receive_input
);
	localparam logic [5:0] PIN_MASK = (SIX_PIN != 0) ? 6'h3F : 6'h0F;

	// ----------------------------------------
	// pad synchronisers
	// ----------------------------------------
	logic [5:0] pad_s1_q, pad_s2_q;
	logic       in7_s1_q, in7_s2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_s1_q <= 6'h00;
			pad_s2_q <= 6'h00;
			in7_s1_q <= 1'b0;
			in7_s2_q <= 1'b0;
		end else if (clk_en) begin
			pad_s1_q <= pad_in;
			pad_s2_q <= pad_s1_q;
			in7_s1_q <= input_only_pin;
			in7_s2_q <= in7_s1_q;
		end
	end

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	phm_wst_t   wst_q, wst_d;
	logic       aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [11:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic        ws_q, ws_d;
	logic [1:0]  bresp_q, bresp_d;
	logic [5:0]  dir_q, dir_d, latch_q, latch_d;
	phm_ctrl_t   ctrl_q, ctrl_d;
	logic        aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d, bvalid_q, bvalid_d;

	always_comb begin
		wst_d     = wst_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awa_d     = awa_q;
		wd_d      = wd_q;
		ws_d      = ws_q;
		bresp_d   = bresp_q;
		dir_d     = dir_q;
		latch_d   = latch_q;
		ctrl_d    = ctrl_q;
		bvalid_d  = bvalid_q;
		unique case (wst_q)
			PHM_W_IDLE: begin
				if (s_axi_awvalid && aw_rdy_q) begin
					aw_have_d = 1'b1;
					awa_d     = s_axi_awaddr;
				end
				if (s_axi_wvalid && w_rdy_q) begin
					w_have_d = 1'b1;
					wd_d     = s_axi_wdata;
					ws_d     = s_axi_wstrb[0];
				end
				if (aw_have_q && w_have_q) begin
					bresp_d = `PHM_RESP_OKAY;
					unique case (awa_q)
						`PHM_OFS_DIR: if (ws_q) dir_d = wd_q[5:0] & PIN_MASK;
						`PHM_OFS_LATCH: if (ws_q) latch_d = wd_q[5:0] & PIN_MASK;
						`PHM_OFS_STATE: ;
						// fields placed by bit position; struct order would put column enable at bit 3
						`PHM_OFS_CTRL: if (ws_q) begin
							ctrl_d.tone_column_output_enable = wd_q[`PHM_CTRL_COL];
							ctrl_d.tone_row_output_enable    = wd_q[`PHM_CTRL_ROW];
							ctrl_d.serial_receive_pin_select = wd_q[`PHM_CTRL_RXS];
							ctrl_d.serial_receiver_enable    = wd_q[`PHM_CTRL_RE];
						end
						default: bresp_d = `PHM_RESP_SLVERR;
					endcase
					aw_have_d = 1'b0;
					w_have_d  = 1'b0;
					bvalid_d  = 1'b1;
					wst_d     = PHM_W_RESP;
				end
			end
			PHM_W_RESP: begin
				if (s_axi_bready) begin
					bvalid_d = 1'b0;
					wst_d    = PHM_W_IDLE;
				end
			end
		endcase
		aw_rdy_d = (wst_d == PHM_W_IDLE) && !aw_have_d;
		w_rdy_d  = (wst_d == PHM_W_IDLE) && !w_have_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wst_q     <= PHM_W_IDLE;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awa_q     <= 12'h000;
			wd_q      <= 32'h00000000;
			ws_q      <= 1'b0;
			bresp_q   <= `PHM_RESP_OKAY;
			dir_q     <= 6'h00;
			latch_q   <= 6'h00;
			ctrl_q    <= 4'h0;
			aw_rdy_q  <= 1'b0;
			w_rdy_q   <= 1'b0;
			bvalid_q  <= 1'b0;
		end else if (clk_en) begin
			wst_q     <= wst_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awa_q     <= awa_d;
			wd_q      <= wd_d;
			ws_q      <= ws_d;
			bresp_q   <= bresp_d;
			dir_q     <= dir_d;
			latch_q   <= latch_d;
			ctrl_q    <= ctrl_d;
			aw_rdy_q  <= aw_rdy_d;
			w_rdy_q   <= w_rdy_d;
			bvalid_q  <= bvalid_d;
		end
	end

	// ----------------------------------------
	// pin multiplexing
	// ----------------------------------------
	logic       tone_on, rx_on;
	logic [5:0] owned, state_bits;
	always_comb begin
		tone_on = ctrl_q.tone_column_output_enable | ctrl_q.tone_row_output_enable;
		rx_on   = (SIX_PIN != 0) && ctrl_q.serial_receive_pin_select && ctrl_q.serial_receiver_enable;
		owned   = {rx_on, 5'h00};
		// reserved bits read zero so software never sees stray pad noise
		state_bits = ((dir_q & latch_q) | (~dir_q & pad_s2_q)) & PIN_MASK;
	end

	logic [5:0] pout_q, poe_q;
	logic       tsel_q, tmr_q, rxi_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pout_q <= 6'h00;
			poe_q  <= 6'h00;
			tsel_q <= 1'b0;
			tmr_q  <= 1'b0;
			rxi_q  <= 1'b1;
		end else if (clk_en) begin
			pout_q <= latch_q;
			poe_q  <= dir_q & ~owned & PIN_MASK;
			tsel_q <= tone_on;
			tmr_q  <= tone_on ? 1'b0 : in7_s2_q;
			rxi_q  <= rx_on ? pad_s2_q[5] : 1'b1;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic        ar_rdy_q, ar_rdy_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	always_comb begin
		ar_rdy_d = ar_rdy_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q) begin
			if (s_axi_rready) begin
				rvalid_d = 1'b0;
				ar_rdy_d = 1'b1;
			end
		end else if (s_axi_arvalid && ar_rdy_q) begin
			ar_rdy_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d  = `PHM_RESP_OKAY;
			rdata_d  = 32'h00000000;
			unique case (s_axi_araddr)
				`PHM_OFS_DIR: rdata_d[7:0] = `PHM_RSVD_READ;
				`PHM_OFS_LATCH: rdata_d[5:0] = latch_q;
				`PHM_OFS_STATE: rdata_d[7:0] = {in7_s2_q, 1'b0, state_bits};
				`PHM_OFS_CTRL: begin
					rdata_d[`PHM_CTRL_COL] = ctrl_q.tone_column_output_enable;
					rdata_d[`PHM_CTRL_ROW] = ctrl_q.tone_row_output_enable;
					rdata_d[`PHM_CTRL_RXS] = ctrl_q.serial_receive_pin_select;
					rdata_d[`PHM_CTRL_RE]  = ctrl_q.serial_receiver_enable;
				end
				default: rresp_d = `PHM_RESP_SLVERR;
			endcase
		end else begin
			ar_rdy_d = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `PHM_RESP_OKAY;
		end else if (clk_en) begin
			ar_rdy_q <= ar_rdy_d;
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	assign s_axi_awready = aw_rdy_q;
	assign s_axi_wready  = w_rdy_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ar_rdy_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign pad_out       = pout_q;
	assign pad_oe        = poe_q;
	assign tone_pin_select          = tsel_q;
	assign reload_timer_clock_input = tmr_q;
	assign serial_receive_input     = rxi_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence rd_state_s;
		s_axi_arvalid && ar_rdy_q && !rvalid_q && clk_en && s_axi_araddr == `PHM_OFS_STATE;
	endsequence
	latch_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wst_q == PHM_W_IDLE && aw_have_q && w_have_q && ws_q && awa_q == `PHM_OFS_LATCH
		|=> latch_q == ($past(wd_q[5:0]) & PIN_MASK))
		else $error("latch write not masked");
	latch_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		rvalid_q |-> rdata_q[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	state_bit7_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_state_s |=> rdata_q[7] == $past(in7_s2_q))
		else $error("bit 7 not input pin");
	state_mix_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_state_s |=> rdata_q[5:0] == ($past(state_bits)))
		else $error("pin state mix wrong");
	state_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_state_s |=> rdata_q[6] == 1'b0)
		else $error("bit 6 not zero");
	dir_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_arvalid && ar_rdy_q && !rvalid_q && clk_en && s_axi_araddr == `PHM_OFS_DIR |=> rdata_q == 32'h0)
		else $error("direction readable");
	tone_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && tone_on |=> !tmr_q && tsel_q)
		else $error("tone mux wrong");
	rx_own_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && rx_on |=> !poe_q[5])
		else $error("pin 5 driven in rx mode");
	drive_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en |=> poe_q == ($past(dir_q) & ~$past(owned) & PIN_MASK))
		else $error("output enable wrong");
	wr_state_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wst_q == PHM_W_IDLE && aw_have_q && w_have_q && awa_q == `PHM_OFS_STATE
		|=> $stable(latch_q) && $stable(dir_q))
		else $error("state write had effect");
	latch_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> latch_q == 6'h00)
		else $error("latch not reset");
	tone_free_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !tone_on |=> !tsel_q && tmr_q == $past(in7_s2_q))
		else $error("input-only pin not general");
	rx_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && rx_on |=> rxi_q == $past(pad_s2_q[5]))
		else $error("receive input not pin 5");
	rx_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !rx_on |=> rxi_q)
		else $error("receive input not idle");
	pad_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en |=> pout_q == $past(latch_q))
		else $error("pad data not latch");
endmodule

// file: test/phm_port_test.sv
`timescale 1ns/1ps
`include "phm_consts.svh"
module phm_port_test
	import phm_pkg::*;
;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, in7, run_en;
	logic        awready, wready, bvalid, arready, rvalid, tone_sel, tmr_clk, rx_in;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_q;
	logic [1:0]  bresp, rresp, resp_q;
	logic [5:0]  pad_in, pad_out, pad_oe;
	logic [4:0]  f;
	logic [3:0]  strb;
	int          miscompares, samples_checked, waits;

	phm_port #(.SIX_PIN(1)) i_phm_port (.clk(clk), .rst_n(rst_n), .clk_en(run_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .input_only_pin(in7),
		.tone_analog_output(1'b0), .tone_pin_select(tone_sel),
		.reload_timer_clock_input(tmr_clk), .serial_receive_input(rx_in));

	always #2 clk = ~clk;

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// flags read at the falling edge are what the next rising edge samples
	task step;
		@(negedge clk);
		f = {awready, wready, bvalid, arready, rvalid};
		rd_q = rdata;
		resp_q = rvalid ? rresp : bresp;
		waits++;
		@(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		waits = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((pa || pw) && waits < 40) begin
			step();
			if (f[4])
				pa = 1'b0;
			if (f[3])
				pw = 1'b0;
			awvalid <= pa;
			wvalid <= pw;
		end
		do step(); while (!f[2] && waits < 40);
		bready <= 1'b0;
		// one edge apart so the next call never re-drives bready in this step
		@(posedge clk);
		if (waits >= 40)
			miscompares++;
	endtask

	task rc(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		waits = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do step(); while (!f[1] && waits < 40);
		arvalid <= 1'b0;
		do step(); while (!f[0] && waits < 40);
		rready <= 1'b0;
		@(posedge clk);
		if (waits >= 40)
			miscompares++;
		chk(nm, {resp_q, rd_q}, {r, e});
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int c;
		clk = 0;
		rst_n = 0;
		{awvalid, wvalid, bready, arvalid, rready, in7} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		pad_in = '0;
		run_en = 1'b1;
		strb = 4'hF;
		miscompares = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc("latch_rst", `PHM_OFS_LATCH, 32'h0, `PHM_RESP_OKAY);
		chk("oe_rst", pad_oe, 6'h00);
		wr(`PHM_OFS_DIR, 32'h0000_00FF);
		wr(`PHM_OFS_LATCH, 32'h0000_00FF);
		rc("dir_rd", `PHM_OFS_DIR, 32'h0, `PHM_RESP_OKAY);
		rc("latch_rd", `PHM_OFS_LATCH, 32'h3F, `PHM_RESP_OKAY);
		pad_in <= 6'h15;
		in7 <= 1'b1;
		repeat (5) @(posedge clk);
		chk("pad_out", pad_out, 6'h3F);
		chk("pad_oe", pad_oe, 6'h3F);
		rc("state_out", `PHM_OFS_STATE, 32'hBF, `PHM_RESP_OKAY);
		wr(`PHM_OFS_STATE, 32'h0);
		chk("state_wr_resp", resp_q, `PHM_RESP_OKAY);
		rc("latch_keep", `PHM_OFS_LATCH, 32'h3F, `PHM_RESP_OKAY);
		strb <= 4'h0;
		wr(`PHM_OFS_LATCH, 32'h0000_0000);
		strb <= 4'hF;
		rc("strb_keep", `PHM_OFS_LATCH, 32'h3F, `PHM_RESP_OKAY);
		wr(`PHM_OFS_LATCH, 32'h0000_002A);
		wr(`PHM_OFS_DIR, 32'h0000_000F);
		repeat (5) @(posedge clk);
		rc("state_mix", `PHM_OFS_STATE, 32'h9A, `PHM_RESP_OKAY);
		chk("oe_mix", pad_oe, 6'h0F);
		rc("unmapped", 12'h010, 32'h0, `PHM_RESP_SLVERR);
		wr(12'h010, 32'h0000_00FF);
		chk("wr_unmapped", resp_q, `PHM_RESP_SLVERR);
		rc("latch_unmapped", `PHM_OFS_LATCH, 32'h2A, `PHM_RESP_OKAY);
		for (c = 0; c < 4; c++) begin
			wr(`PHM_OFS_CTRL, c);
			repeat (5) @(posedge clk);
			chk("tone_sel", tone_sel, c != 0);
			chk("tmr_clk", tmr_clk, c == 0);
		end
		wr(`PHM_OFS_DIR, 32'h0000_0020);
		wr(`PHM_OFS_CTRL, 32'h0000_000C);
		pad_in <= 6'h00;
		repeat (5) @(posedge clk);
		chk("rx_low", rx_in, 1'b0);
		chk("rx_oe", pad_oe, 6'h00);
		pad_in <= 6'h20;
		repeat (5) @(posedge clk);
		chk("rx_high", rx_in, 1'b1);
		pad_in <= 6'h00;
		wr(`PHM_OFS_CTRL, 32'h0000_0004);
		repeat (5) @(posedge clk);
		chk("rx_idle", rx_in, 1'b1);
		chk("gp_oe", pad_oe, 6'h20);
		run_en <= 1'b0;
		in7 <= 1'b0;
		repeat (5) @(posedge clk);
		chk("tmr_frozen", tmr_clk, 1'b1);
		run_en <= 1'b1;
		repeat (5) @(posedge clk);
		chk("tmr_follow", tmr_clk, 1'b0);
		rc("state_in7", `PHM_OFS_STATE, 32'h20, `PHM_RESP_OKAY);
		end_sim();
	end

	// hang guard, far beyond the whole sequence
	initial begin
		#40000;
		miscompares++;
		end_sim();
	end
endmodule
